// ### logic/sbcrb_device.sv
`timescale 1ns/1ps
// What this block does
// - One frame: address byte then data byte
// - Bit seven low reads, data discarded
// - Bit seven high writes control bytes, clears status bits written as one except wake level status
// - Data D0..D7 on frame bits 8..15
// - Reserved bits always read as zero
// - Host writes zero into reserved bits
// - Reset loads power-on defaults everywhere
// - Restart loads restart values, keeps marked bits
// - Read-only, read/write and hardware-updatable bits
// - Only hardware-updatable control bits and status bits change by themselves
// - Host changes control bits by writing
// - Each address selects one whole byte
// - Write frame returns the old content
module sbcrb_device #(
  parameter logic [7:0] FAMILY_ID = 8'hA5  // Arbitrary identity value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  sbcrb_link_if.dev link,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic hw_upd_valid,
  input wire logic [4:0] hw_upd_index,
  input wire logic [7:0] hw_upd_data,
  input wire logic [7:0] hw_upd_mask,
  input wire logic [sbcrb_pkg::NSTAT-1:0][7:0] stat_set,
  output logic [sbcrb_pkg::NCTRL-1:0][7:0] ctrl_q
);
  typedef enum logic [1:0] {
    SBCRB_D_IDLE = 2'h0,
    SBCRB_D_ADDR = 2'h1,
    SBCRB_D_DATA = 2'h3
  } sbcrb_dstate_type;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic csn_s1;
    logic csn_s2;
    logic mosi_s1;
    logic mosi_s2;
    sbcrb_dstate_type state;
    logic [4:0] cnt;
    logic [15:0] rx;
    logic [7:0] tx;
    logic miso;
    sbcrb_pkg::sbcrb_regs_type regs;
  } sbcrb_dev_type;

  sbcrb_dev_type r_reg;
  sbcrb_dev_type r_next;

  function automatic logic [7:0] read_val(
    input logic [6:0] addr,
    input sbcrb_pkg::sbcrb_regs_type regs
  );
    logic [5:0] f;
    logic [7:0] v;
    f = sbcrb_pkg::find_idx(addr);
    v = 8'h00;
    if (f[5]) begin
      v = regs[f[4:0]] & ~sbcrb_pkg::REG_RSV[f[4:0]];
    end
    return v;
  endfunction

  // New content of a register hit by a host write
  function automatic logic [7:0] host_write(
    input logic [4:0] idx,
    input logic [7:0] old,
    input logic [7:0] data
  );
    logic [7:0] v;
    v = old;
    if (int'(idx) < sbcrb_pkg::NCTRL) begin
      v = data;
    end else if (int'(idx) != sbcrb_pkg::IDX_WAKE_LEVEL &&
                 int'(idx) != sbcrb_pkg::IDX_FAMILY_ID) begin
      v = old & ~data;
    end
    return v;
  endfunction

  // Next content of a status register from its set bits
  function automatic logic [7:0] status_next(
    input int idx,
    input logic [7:0] cur,
    input logic [7:0] flags
  );
    logic [7:0] v;
    v = cur | flags;
    if (idx == sbcrb_pkg::IDX_WAKE_LEVEL) begin
      v = flags;
    end
    return v;
  endfunction

  logic rise;
  logic fall;
  logic wr_go;
  logic [5:0] wf;
  logic [7:0] wdata;

  always_comb begin
    r_next = r_reg;
    r_next.sclk_s1 = link.sclk;
    r_next.sclk_s2 = r_reg.sclk_s1;
    r_next.sclk_s3 = r_reg.sclk_s2;
    r_next.csn_s1 = link.cs_n;
    r_next.csn_s2 = r_reg.csn_s1;
    r_next.mosi_s1 = link.mosi;
    r_next.mosi_s2 = r_reg.mosi_s1;
    rise = r_reg.sclk_s2 & ~r_reg.sclk_s3;
    fall = ~r_reg.sclk_s2 & r_reg.sclk_s3;
    wr_go = 1'b0;
    if (r_reg.csn_s2) begin
      if (r_reg.state == SBCRB_D_DATA &&
          r_reg.cnt == sbcrb_pkg::CNT_FULL) begin
        wr_go = r_reg.rx[sbcrb_pkg::RW_BIT];
      end
      r_next.state = SBCRB_D_IDLE;
      r_next.cnt = 5'h00;
      r_next.miso = 1'b0;
    end else begin
      case (r_reg.state)
        SBCRB_D_IDLE: begin
          r_next.state = SBCRB_D_ADDR;
          r_next.cnt = 5'h00;
          r_next.miso = 1'b0;
        end
        SBCRB_D_ADDR: begin
          if (rise) begin
            r_next.rx[r_reg.cnt[3:0]] = r_reg.mosi_s2;
            r_next.cnt = r_reg.cnt + 5'h01;
            if (r_reg.cnt == sbcrb_pkg::CNT_RW) begin
              r_next.tx = read_val(r_reg.rx[6:0], r_reg.regs);
              r_next.state = SBCRB_D_DATA;
            end
          end
        end
        SBCRB_D_DATA: begin
          if (rise && r_reg.cnt < sbcrb_pkg::CNT_FULL) begin
            r_next.rx[r_reg.cnt[3:0]] = r_reg.mosi_s2;
            r_next.cnt = r_reg.cnt + 5'h01;
          end
          if (fall) begin
            r_next.miso = 1'b0;
            if (r_reg.cnt < sbcrb_pkg::CNT_FULL) begin
              r_next.miso = r_reg.tx[r_reg.cnt[2:0]];
            end
          end
        end
        default: begin
          r_next.state = SBCRB_D_IDLE;
        end
      endcase
    end
    // Host write at frame end
    wf = sbcrb_pkg::find_idx(r_reg.rx[6:0]);
    wdata = r_reg.rx[15:8] & ~sbcrb_pkg::REG_RSV[wf[4:0]];
    if (wr_go && wf[5]) begin
      r_next.regs[wf[4:0]] = host_write(wf[4:0], r_reg.regs[wf[4:0]],
        wdata);
    end
    // Hardware updates of updatable control bits only
    if (hw_upd_valid && int'(hw_upd_index) < sbcrb_pkg::NCTRL) begin
      r_next.regs[hw_upd_index] = (r_next.regs[hw_upd_index] &
        ~(hw_upd_mask & sbcrb_pkg::REG_RWH[hw_upd_index])) |
        (hw_upd_data & hw_upd_mask &
        sbcrb_pkg::REG_RWH[hw_upd_index]);
    end
    // Sticky status flags, set wins over clear; wake level status follows stat_set
    for (int j = 0; j < sbcrb_pkg::NSTAT; j++) begin
      r_next.regs[sbcrb_pkg::STAT_FIRST + j] = status_next(
        sbcrb_pkg::STAT_FIRST + j, r_next.regs[sbcrb_pkg::STAT_FIRST + j],
        stat_set[j]);
    end
    r_next.regs[sbcrb_pkg::IDX_FAMILY_ID] = FAMILY_ID;
    if (restart) begin
      r_next.regs = (r_next.regs & sbcrb_pkg::REG_KEEP) |
        (sbcrb_pkg::REG_POR & ~sbcrb_pkg::REG_KEEP);
    end
    if (soft_reset) begin
      r_next.regs = sbcrb_pkg::REG_POR;
      r_next.regs[sbcrb_pkg::IDX_FAMILY_ID] = FAMILY_ID;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.csn_s1 <= 1'b1;
      r_reg.csn_s2 <= 1'b1;
      r_reg.regs <= sbcrb_pkg::REG_POR;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.miso = r_reg.miso;

  always_comb begin
    for (int i = 0; i < sbcrb_pkg::NCTRL; i++) begin
      ctrl_q[i] = r_reg.regs[i];
    end
  end
endmodule // sbcrb_device

// ### logic/sbcrb_pkg.sv
package sbcrb_pkg;
  localparam int NREG = 31;
  localparam int NCTRL = 19;
  localparam int STAT_FIRST = 19;
  localparam int NSTAT = 11;
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam logic [4:0] CNT_RW = 5'h07;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] BIT_DATA = 4'h8;
  localparam int IDX_MODE_SUPPLY = 0;
  localparam int IDX_HW_CONFIG = 1;
  localparam int IDX_WAKE_LEVEL = 27;
  localparam int IDX_FAMILY_ID = 30;
  // Last divider count of a link clock half period made by the host (8 sys_clk cycles)
  localparam logic [3:0] SCLK_HALF_LAST = 4'h7;

  localparam logic [6:0] ADDR_MODE_SUPPLY_CONTROL = 7'h01;
  localparam logic [6:0] ADDR_HARDWARE_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;
  localparam logic [6:0] ADDR_BUS_CONTROL_ONE = 7'h04;
  localparam logic [6:0] ADDR_BUS_CONTROL_TWO = 7'h05;
  localparam logic [6:0] ADDR_WAKE_CONTROL_ONE = 7'h06;
  localparam logic [6:0] ADDR_WAKE_CONTROL_TWO = 7'h07;
  localparam logic [6:0] ADDR_WAKE_PULL_CONFIG = 7'h08;
  localparam logic [6:0] ADDR_WAKE_FILTER_CONFIG = 7'h09;
  localparam logic [6:0] ADDR_TIMER_ONE_CONTROL = 7'h0C;
  localparam logic [6:0] ADDR_TIMER_TWO_CONTROL = 7'h0D;
  localparam logic [6:0] ADDR_SWITCH_SHUTDOWN_CONTROL = 7'h10;
  localparam logic [6:0] ADDR_HIGHSIDE_CONTROL_ONE = 7'h14;
  localparam logic [6:0] ADDR_HIGHSIDE_CONTROL_TWO = 7'h15;
  localparam logic [6:0] ADDR_GENERAL_IO_CONTROL = 7'h17;
  localparam logic [6:0] ADDR_PWM_ONE_DUTY = 7'h18;
  localparam logic [6:0] ADDR_PWM_TWO_DUTY = 7'h19;
  localparam logic [6:0] ADDR_PWM_FREQUENCY_SELECT = 7'h1C;
  localparam logic [6:0] ADDR_SYSTEM_SCRATCH_STATUS = 7'h1E;
  localparam logic [6:0] ADDR_SUPPLY_STATUS_TWO = 7'h40;
  localparam logic [6:0] ADDR_SUPPLY_STATUS_ONE = 7'h41;
  localparam logic [6:0] ADDR_THERMAL_STATUS = 7'h42;
  localparam logic [6:0] ADDR_DEVICE_STATUS = 7'h43;
  localparam logic [6:0] ADDR_BUS_STATUS_ONE = 7'h44;
  localparam logic [6:0] ADDR_BUS_STATUS_TWO = 7'h45;
  localparam logic [6:0] ADDR_WAKE_STATUS_ONE = 7'h46;
  localparam logic [6:0] ADDR_WAKE_STATUS_TWO = 7'h47;
  localparam logic [6:0] ADDR_WAKE_LEVEL_STATUS = 7'h48;
  localparam logic [6:0] ADDR_HIGHSIDE_FAULT_STATUS = 7'h54;
  localparam logic [6:0] ADDR_HIGHSIDE_OPENLOAD_STATUS = 7'h55;
  localparam logic [6:0] ADDR_FAMILY_PRODUCT_ID = 7'h7E;

  typedef logic [7:0] sbcrb_byte_type;
  typedef logic [NREG-1:0][7:0] sbcrb_regs_type;
  typedef logic [NREG-1:0][6:0] sbcrb_addrs_type;

  localparam sbcrb_addrs_type REG_ADDR = '{
    0: ADDR_MODE_SUPPLY_CONTROL, 1: ADDR_HARDWARE_CONFIG,
    2: ADDR_WATCHDOG_CONTROL, 3: ADDR_BUS_CONTROL_ONE,
    4: ADDR_BUS_CONTROL_TWO, 5: ADDR_WAKE_CONTROL_ONE,
    6: ADDR_WAKE_CONTROL_TWO, 7: ADDR_WAKE_PULL_CONFIG,
    8: ADDR_WAKE_FILTER_CONFIG, 9: ADDR_TIMER_ONE_CONTROL,
    10: ADDR_TIMER_TWO_CONTROL, 11: ADDR_SWITCH_SHUTDOWN_CONTROL,
    12: ADDR_HIGHSIDE_CONTROL_ONE, 13: ADDR_HIGHSIDE_CONTROL_TWO,
    14: ADDR_GENERAL_IO_CONTROL, 15: ADDR_PWM_ONE_DUTY,
    16: ADDR_PWM_TWO_DUTY, 17: ADDR_PWM_FREQUENCY_SELECT,
    18: ADDR_SYSTEM_SCRATCH_STATUS, 19: ADDR_SUPPLY_STATUS_TWO,
    20: ADDR_SUPPLY_STATUS_ONE, 21: ADDR_THERMAL_STATUS,
    22: ADDR_DEVICE_STATUS, 23: ADDR_BUS_STATUS_ONE,
    24: ADDR_BUS_STATUS_TWO, 25: ADDR_WAKE_STATUS_ONE,
    26: ADDR_WAKE_STATUS_TWO, 27: ADDR_WAKE_LEVEL_STATUS,
    28: ADDR_HIGHSIDE_FAULT_STATUS, 29: ADDR_HIGHSIDE_OPENLOAD_STATUS,
    30: ADDR_FAMILY_PRODUCT_ID};

  // Reserved bit positions, one byte per register
  localparam sbcrb_regs_type REG_RSV = '{
    1: 8'h04, 3: 8'h04, 4: 8'hDF, 5: 8'h3B, 6: 8'h58, 7: 8'hC0,
    8: 8'hC0, 9: 8'h88, 10: 8'h88, 11: 8'h8F, 12: 8'h88, 13: 8'h88,
    17: 8'hFA, 19: 8'hA0, 21: 8'hB8, 22: 8'h30, 23: 8'h98, 24: 8'hFF,
    25: 8'h88, 26: 8'hCF, 27: 8'h08, 28: 8'hF0, 29: 8'hC0,
    default: 8'h00};
  // Control bits that hardware may also change
  localparam sbcrb_regs_type REG_RWH = '{
    0: 8'hFC, 1: 8'h20, default: 8'h00};
  // Values after power-on or soft reset
  localparam sbcrb_regs_type REG_POR = '{default: 8'h00};
  // Bits left unchanged by a restart
  localparam sbcrb_regs_type REG_KEEP = '{
    0: 8'h23, 1: 8'hD9, default: 8'hFF};

  // Returns {hit, index} for a register address
  function automatic logic [5:0] find_idx(input logic [6:0] addr);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < NREG; i++) begin
      if (REG_ADDR[i] == addr) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction
endpackage

// ### logic/sbcrb_link_if.sv
`timescale 1ns/1ps
interface sbcrb_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ### logic/sbcrb_host.sv
`timescale 1ns/1ps
module sbcrb_host (
  input wire logic sys_clk,
  input wire logic arst_n,
  sbcrb_link_if.host link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum logic [2:0] {
    SBCRB_H_IDLE = 3'h0,
    SBCRB_H_LEAD = 3'h1,
    SBCRB_H_HIGH = 3'h3,
    SBCRB_H_LOW = 3'h2,
    SBCRB_H_TAIL = 3'h6,
    SBCRB_H_GAP = 3'h7
  } sbcrb_hstate_type;

  typedef struct packed {
    sbcrb_hstate_type state;
    logic [3:0] div;
    logic [3:0] bitn;
    logic [15:0] frame;
    logic [7:0] rx;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso_s1;
    logic miso_s2;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } sbcrb_host_type;

  sbcrb_host_type r_reg;
  sbcrb_host_type r_next;
  logic half_done;
  logic [5:0] f;
  logic [7:0] wbyte;

  always_comb begin
    r_next = r_reg;
    r_next.miso_s1 = link.miso;
    r_next.miso_s2 = r_reg.miso_s1;
    r_next.rsp_valid = 1'b0;
    r_next.div = r_reg.div + 4'h1;
    half_done = r_reg.div == sbcrb_pkg::SCLK_HALF_LAST;
    f = sbcrb_pkg::find_idx(req_addr);
    wbyte = 8'h00;
    if (req_write) begin
      wbyte = req_data & ~sbcrb_pkg::REG_RSV[f[4:0]];
    end
    case (r_reg.state)
      SBCRB_H_IDLE: begin
        r_next.div = 4'h0;
        if (req_valid) begin
          r_next.frame = {wbyte, req_write, req_addr};
          r_next.csn = 1'b0;
          r_next.mosi = req_addr[0];
          r_next.bitn = 4'h0;
          r_next.state = SBCRB_H_LEAD;
        end
      end
      SBCRB_H_LEAD: begin
        if (half_done) begin
          r_next.div = 4'h0;
          r_next.sclk = 1'b1;
          r_next.state = SBCRB_H_HIGH;
        end
      end
      SBCRB_H_HIGH: begin
        if (half_done) begin
          r_next.div = 4'h0;
          r_next.sclk = 1'b0;
          if (r_reg.bitn == sbcrb_pkg::BIT_LAST) begin
            r_next.state = SBCRB_H_TAIL;
          end else begin
            r_next.bitn = r_reg.bitn + 4'h1;
            r_next.mosi = r_reg.frame[r_reg.bitn + 4'h1];
            r_next.state = SBCRB_H_LOW;
          end
        end
      end
      SBCRB_H_LOW: begin
        if (half_done) begin
          r_next.div = 4'h0;
          r_next.sclk = 1'b1;
          if (r_reg.bitn >= sbcrb_pkg::BIT_DATA) begin
            r_next.rx[r_reg.bitn[2:0]] = r_reg.miso_s2;
          end
          r_next.state = SBCRB_H_HIGH;
        end
      end
      SBCRB_H_TAIL: begin
        if (half_done) begin
          r_next.div = 4'h0;
          r_next.csn = 1'b1;
          r_next.mosi = 1'b0;
          r_next.rsp_valid = 1'b1;
          r_next.rsp_data = r_reg.rx;
          r_next.state = SBCRB_H_GAP;
        end
      end
      SBCRB_H_GAP: begin
        if (half_done) begin
          r_next.div = 4'h0;
          r_next.state = SBCRB_H_IDLE;
        end
      end
      default: begin
        r_next.state = SBCRB_H_IDLE;
      end
    endcase
    r_next.ready = r_next.state == SBCRB_H_IDLE;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.csn <= 1'b1;
      r_reg.ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sclk = r_reg.sclk;
  assign link.cs_n = r_reg.csn;
  assign link.mosi = r_reg.mosi;
  assign req_ready = r_reg.ready;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data = r_reg.rsp_data;
endmodule // sbcrb_host

// ### sim/sbcrb_link_monitor.sv
`timescale 1ns/1ps
module sbcrb_link_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic [4:0] rise_cnt_reg;

  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Rising link clock edges within the current frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_cnt_reg <= 5'h00;
    end else if (cs_n) begin
      rise_cnt_reg <= 5'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
  end

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  a_frame_span: assert property ($fell(cs_n) |-> ##264 $rose(cs_n))
    else $error("frame select length wrong");
  a_bit_count: assert property ($rose(cs_n) |-> rise_cnt_reg == 5'h10)
    else $error("frame without sixteen clock edges");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase wrong");
  a_low_half: assert property ($fell(sclk) && !cs_n |-> !sclk [*8])
    else $error("link clock low phase too short");
  a_mosi_steady: assert property ($rose(sclk) |=> $stable(mosi) [*7])
    else $error("host data moved while clock high");
  a_addr_quiet: assert property (
    !cs_n && rise_cnt_reg < 5'h08 |-> !miso)
    else $error("device data during address byte");
  a_data_steady: assert property (
    $rose(sclk) && rise_cnt_reg >= 5'h08 |=> $stable(miso) [*7])
    else $error("device data moved while clock high");
  a_miso_idle: assert property (cs_n [*8] |-> !miso)
    else $error("device data outside a frame");
endmodule // sbcrb_link_monitor

// ### sim/sbcrb_spi_register_bank_tb.sv
`timescale 1ns/1ps
module sbcrb_spi_register_bank_tb;
  localparam logic [7:0] FAM = 8'h3C; // Arbitrary identity value
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic restart = 1'b0;
  logic hw_upd_valid = 1'b0;
  logic [4:0] hw_upd_index = 5'h00;
  logic [7:0] hw_upd_data = 8'h00;
  logic [7:0] hw_upd_mask = 8'h00;
  logic [sbcrb_pkg::NSTAT-1:0][7:0] stat_set = '0;
  logic [sbcrb_pkg::NCTRL-1:0][7:0] ctrl_q;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_data = 8'h00;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic sclk_q = 1'b0;
  logic [15:0] cap_mosi = 16'h0000;
  logic [15:0] cap_miso = 16'h0000;
  logic [7:0] wmask = 8'hFF;
  int err_count = 0;
  int checked = 0;

  sbcrb_link_if lk ();
  sbcrb_device #(.FAMILY_ID(FAM)) u_sbcrb_device (.sys_clk(sys_clk),
    .arst_n(arst_n), .link(lk), .soft_reset(soft_reset),
    .restart(restart), .hw_upd_valid(hw_upd_valid),
    .hw_upd_index(hw_upd_index), .hw_upd_data(hw_upd_data),
    .hw_upd_mask(hw_upd_mask), .stat_set(stat_set), .ctrl_q(ctrl_q));
  sbcrb_host u_sbcrb_host (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(lk), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sbcrb_link_monitor u_sbcrb_link_monitor (.sys_clk(sys_clk),
    .arst_n(arst_n), .sclk(lk.sclk), .cs_n(lk.cs_n), .mosi(lk.mosi),
    .miso(lk.miso));

  always #5 sys_clk = ~sys_clk;

  // Frame bits seen on the wire, first bit ends up lowest
  always @(posedge sys_clk) begin
    sclk_q <= lk.sclk;
    if (lk.sclk && !sclk_q) begin
      cap_mosi <= {lk.mosi, cap_mosi[15:1]};
      cap_miso <= {lk.miso, cap_miso[15:1]};
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One frame: request, wait for the answer, check both wire directions
  task automatic acc(input logic w, input logic [6:0] a,
      input logic [7:0] d, input logic [7:0] exp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n < 400), 16'h0001);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    tick(1);
    req_valid = 1'b0;
    chk(16'(req_ready), 16'h0000);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n < 400), 16'h0001);
    chk(rsp_data, exp);
    chk(cap_miso[15:8], exp);
    chk(cap_mosi, {w ? d & wmask : 8'h00, w, a});
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(6);
    arst_n = 1'b1;
    tick(1);
    chk(16'(ctrl_q === '0), 16'h0001);
    acc(1'b0, sbcrb_pkg::ADDR_PWM_ONE_DUTY, 8'h00, 8'h00);
    acc(1'b0, sbcrb_pkg::ADDR_FAMILY_PRODUCT_ID, 8'h00, FAM);
    acc(1'b1, sbcrb_pkg::ADDR_FAMILY_PRODUCT_ID, 8'h55, FAM);
    acc(1'b0, sbcrb_pkg::ADDR_FAMILY_PRODUCT_ID, 8'h00, FAM);
    acc(1'b1, sbcrb_pkg::ADDR_PWM_ONE_DUTY, 8'h5A, 8'h00);
    acc(1'b1, sbcrb_pkg::ADDR_PWM_TWO_DUTY, 8'hC3, 8'h00);
    acc(1'b1, sbcrb_pkg::ADDR_PWM_ONE_DUTY, 8'hA5, 8'h5A);
    acc(1'b0, sbcrb_pkg::ADDR_PWM_ONE_DUTY, 8'hFF, 8'hA5);
    chk(ctrl_q[16], 8'hC3);
    wmask = 8'h20;
    acc(1'b1, sbcrb_pkg::ADDR_BUS_CONTROL_TWO, 8'hFF, 8'h00);
    wmask = 8'hFB;
    acc(1'b1, sbcrb_pkg::ADDR_HARDWARE_CONFIG, 8'hFF, 8'h00);
    wmask = 8'hFF;
    acc(1'b0, sbcrb_pkg::ADDR_BUS_CONTROL_TWO, 8'h00, 8'h20);
    acc(1'b1, 7'h0A, 8'hFF, 8'h00);
    acc(1'b0, 7'h0A, 8'h00, 8'h00);
    chk(ctrl_q[15], 8'hA5);
    hw_upd_valid = 1'b1;
    hw_upd_data = 8'hFF;
    hw_upd_mask = 8'hFF;
    tick(1);
    hw_upd_index = 5'h02;
    tick(1);
    hw_upd_valid = 1'b0;
    tick(1);
    chk(ctrl_q[0], 8'hFC);
    chk(ctrl_q[2], 8'h00);
    acc(1'b0, sbcrb_pkg::ADDR_MODE_SUPPLY_CONTROL, 8'h00, 8'hFC);
    stat_set[2] = 8'hFF;
    stat_set[8] = 8'hFF;
    tick(1);
    stat_set[2] = 8'h00;
    acc(1'b0, sbcrb_pkg::ADDR_THERMAL_STATUS, 8'h00, 8'h47);
    acc(1'b1, sbcrb_pkg::ADDR_THERMAL_STATUS, 8'h01, 8'h47);
    acc(1'b0, sbcrb_pkg::ADDR_THERMAL_STATUS, 8'h00, 8'h46);
    acc(1'b0, sbcrb_pkg::ADDR_WAKE_LEVEL_STATUS, 8'h00, 8'hF7);
    restart = 1'b1;
    tick(1);
    restart = 1'b0;
    tick(1);
    chk(ctrl_q[0], 8'h20);
    chk(ctrl_q[1], 8'hD9);
    chk(ctrl_q[15], 8'hA5);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(1);
    chk(16'(ctrl_q === '0), 16'h0001);
    acc(1'b0, sbcrb_pkg::ADDR_THERMAL_STATUS, 8'h00, 8'h00);
    end_sim();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
endmodule // sbcrb_spi_register_bank_tb
